//--- logic/tpc_capture.sv
// tachometer period capture: edge timing, held count, marker, aligned stream
// Operation
// - count periods on a 12 MHz time base
// - starting edge selectable rising or falling
// - start on first edge, capture, clear on next
// - next measurement starts automatically after capture
// - held count kept until replaced; a read only clears freshness
// - marker on: fresh sample MSB 0, old 1
// - marker off: MSB always zero
// - reading keeps count; repeat sample gives it again
// - newer completion overwrites held count
// - tachometer is channel 8 or channel 16
// - delay pipeline aligns value with converter samples
// - sampled like any ordinary channel-list entry
// - before first completion count reads zero
// - reported count is whole periods plus one
`timescale 1ns/100ps
module tpc_capture
(
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          reset,

	// conditioned tachometer pulse from the pin
	input  wire logic                          tacho_in,

	// acquisition control
	input  wire logic                          acq_start,
	input  wire logic                          edge_rise_sel,
	input  wire logic                          stale_en,
	input  wire logic                          variant_16,

	// sample requests from the channel-list sequencer
	input  wire logic                          sample_req,
	input  wire logic [tpc_pkg::CHAN_W-1:0]    sample_chan,
	output logic                               sample_ready,

	// tachometer words into the input data stream
	output logic                               out_valid,
	input  wire logic                          out_ready,
	output logic      [tpc_pkg::DATA_W-1:0]    out_data
);

	// whole module state
	typedef struct packed {
		logic                       sync1;   // first synchroniser stage
		logic                       sync2;   // second synchroniser stage
		logic                       prev;    // last synchronised level
		tpc_pkg::tpc_state_t        st;      // measurement sequencing
		logic [tpc_pkg::ACC_W-1:0]  acc;     // fractional divider phase
		logic                       tick;    // one-cycle 12 MHz enable
		logic [tpc_pkg::CNT_W-1:0]  run;     // running period counter
		logic [tpc_pkg::CNT_W-1:0]  held;    // last completed count
		logic                       fresh;   // held count not yet read
		logic                       pend;    // word in flight from delay line
		logic                       rdy;     // accepting a tachometer sample
	} tpc_top_t;

	tpc_top_t q_ff;      // registered state
	tpc_top_t nxt_q;     // next state

	// internal nets, four of them shared with its two helpers
	logic                        start_edge;   // selected edge seen
	logic [tpc_pkg::ACC_W:0]     acc_sum;      // divider sum, one bit wider
	logic                        chan_hit;     // request names the tachometer
	logic                        take;         // tachometer sample accepted
	logic [tpc_pkg::DATA_W-1:0]  word;         // sample word at the sample instant
	logic [tpc_pkg::DATA_W-1:0]  dly_data;     // word leaving the delay line
	logic                        buf_ready;    // buffer has room
	logic                        push;         // delayed word enters buffer

	// tachometer channel position for this build variant
	always_comb
	begin
		if (variant_16)
			chan_hit = (sample_chan == tpc_pkg::TACHO_CHAN_16);
		else
			chan_hit = (sample_chan == tpc_pkg::TACHO_CHAN_8);
	end

	// a tachometer entry is taken exactly like any other list entry;
	// requests for other channels are not ours and are ignored
	assign take = sample_req && q_ff.rdy && chan_hit;

	// sample word: marker bit over the held count
	always_comb
	begin
		word                                     = '0;
		word[tpc_pkg::CNT_W-1:0]                 = q_ff.held;
		word[tpc_pkg::MARK_BIT]                  = stale_en && !q_ff.fresh;
	end

	// edge detection looks only at the second stage and the stored level
	always_comb
	begin
		if (edge_rise_sel)
			start_edge = q_ff.sync2 && !q_ff.prev;
		else
			start_edge = !q_ff.sync2 && q_ff.prev;
	end

	// divider sum, kept wide so the compare sees the carry
	assign acc_sum = {1'b0, q_ff.acc} + {1'b0, tpc_pkg::ACC_STEP};

	// the delayed word leaves the flight stage once the buffer takes it
	assign push = q_ff.pend && buf_ready;

	// next state of the whole block
	always_comb
	begin
		nxt_q = q_ff;

		// two-stage synchroniser, then one level for the edge compare
		nxt_q.sync1 = tacho_in;
		nxt_q.sync2 = q_ff.sync1;
		nxt_q.prev  = q_ff.sync2;

		// 40 MHz has no integer ratio to 12 MHz, so a phase accumulator
		// spreads three ticks over ten cycles; jitter is one core cycle
		if (acc_sum >= {1'b0, tpc_pkg::ACC_MOD})
		begin
			nxt_q.acc  = tpc_pkg::ACC_W'(acc_sum - {1'b0, tpc_pkg::ACC_MOD});
			nxt_q.tick = 1'b1;
		end
		else
		begin
			nxt_q.acc  = tpc_pkg::ACC_W'(acc_sum);
			nxt_q.tick = 1'b0;
		end

		// a read consumes freshness but leaves the count in place
		if (take)
			nxt_q.fresh = 1'b0;

		// measurement sequencing
		unique case (q_ff.st)
			tpc_pkg::TPC_IDLE:
			begin
				// nothing measured until an acquisition starts
				nxt_q.run = tpc_pkg::CNT_ZERO;
			end
			tpc_pkg::TPC_WAIT_EDGE:
			begin
				// first starting edge opens the first period
				if (start_edge)
				begin
					nxt_q.run = tpc_pkg::CNT_FIRST;
					nxt_q.st  = tpc_pkg::TPC_TIMING;
				end
			end
			tpc_pkg::TPC_TIMING:
			begin
				if (start_edge)
				begin
					// store and restart; a tick on the closing edge still
					// belongs to this period, so whole periods plus one
					// come out the same whatever the divider phase
					if (q_ff.tick && (q_ff.run != tpc_pkg::CNT_MAX))
						nxt_q.held = q_ff.run + tpc_pkg::CNT_FIRST;
					else
						nxt_q.held = q_ff.run;
					// capture sets freshness after any read this cycle,
					// so the new count is never lost
					nxt_q.fresh = 1'b1;
					nxt_q.run   = tpc_pkg::CNT_FIRST;
				end
				else if (q_ff.tick && (q_ff.run != tpc_pkg::CNT_MAX))
				begin
					// saturate rather than wrap on a stalled input
					nxt_q.run = q_ff.run + tpc_pkg::CNT_FIRST;
				end
			end
		endcase

		// acquisition start wins over the measurement state; the flight stage is left alone
		if (acq_start)
		begin
			nxt_q.run   = tpc_pkg::CNT_ZERO;
			nxt_q.held  = tpc_pkg::CNT_ZERO;
			nxt_q.fresh = 1'b0;
			nxt_q.st    = tpc_pkg::TPC_WAIT_EDGE;
		end

		// flight stage between delay line read and buffer
		if (push)
			nxt_q.pend = 1'b0;
		if (take)
			nxt_q.pend = 1'b1;

		// one sample in flight at a time; a full buffer holds us off
		nxt_q.rdy = !nxt_q.pend;
	end

	// state register
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			q_ff       <= '0;
			q_ff.st    <= tpc_pkg::TPC_IDLE;
			q_ff.acc   <= tpc_pkg::ACC_INIT;
			q_ff.rdy   <= 1'b1;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	// fixed delay of tachometer samples to line up with converter data
	tpc_delay_mem u_delay
	(
		.core_clk (core_clk),
		.reset    (reset),
		.clr      (acq_start),
		.wr_en    (take),
		.wr_data  (word),
		.rd_data  (dly_data)
	);

	// two-entry buffer so a stalled stream loses no word
	tpc_skid_buf u_buf
	(
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (q_ff.pend),
		.in_ready  (buf_ready),
		.in_data   (dly_data),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);

	// request handshake back to the sequencer
	assign sample_ready = q_ff.rdy;

endmodule

//--- logic/tpc_pkg.sv
// shared constants and types of the tachometer period capture block
package tpc_pkg;

	// clock rates in mhz: core clock and counting time base
	localparam int CLK_MHZ = 40;
	localparam int CNT_MHZ = 12;

	// fractional divider: accumulate the count rate, wrap at the core rate
	localparam int          ACC_W    = 6;
	localparam logic [5:0]  ACC_STEP = 6'(CNT_MHZ);
	localparam logic [5:0]  ACC_MOD  = 6'(CLK_MHZ);
	localparam logic [5:0]  ACC_INIT = 6'h00;

	// sample word layout
	localparam int          DATA_W   = 32;
	localparam int          CNT_W    = 31;
	localparam int          MARK_BIT = 31;

	// count values
	localparam logic [30:0] CNT_ZERO  = 31'h0;
	localparam logic [30:0] CNT_FIRST = 31'h1;
	localparam logic [30:0] CNT_MAX   = 31'h7fffffff;

	// channel list positions of the tachometer entry
	localparam int          CHAN_W        = 5;
	localparam logic [4:0]  TACHO_CHAN_8  = 5'h08;
	localparam logic [4:0]  TACHO_CHAN_16 = 5'h10;

	// alignment delay, in tachometer samples, matching converter group delay
	localparam int          DELAY_DEPTH = 8;
	localparam int          DELAY_AW    = 3;
	localparam logic [2:0]  PTR_ONE     = 3'h1;

	// measurement sequencing
	typedef enum logic [1:0] {
		TPC_IDLE,
		TPC_WAIT_EDGE,
		TPC_TIMING
	} tpc_state_t;

endpackage

//--- logic/tpc_delay_mem.sv
// delay line memory: read-before-write at one pointer gives a fixed delay
`timescale 1ns/100ps
module tpc_delay_mem
(
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         reset,
	// control
	input  wire logic                         clr,
	input  wire logic                         wr_en,
	// data
	input  wire logic [tpc_pkg::DATA_W-1:0]   wr_data,
	output logic      [tpc_pkg::DATA_W-1:0]   rd_data
);

	// whole module state
	typedef struct packed {
		logic [tpc_pkg::DELAY_DEPTH-1:0][tpc_pkg::DATA_W-1:0] mem;
		logic [tpc_pkg::DELAY_AW-1:0]                         ptr;
		logic [tpc_pkg::DATA_W-1:0]                           rd;
	} tpc_mem_t;

	tpc_mem_t q_ff;      // registered state
	tpc_mem_t nxt_q;     // next state

	// read the oldest word, then overwrite it with the newest
	always_comb
	begin
		nxt_q = q_ff;
		if (clr)
		begin
			// zero contents so early samples read back as zero
			nxt_q = '0;
		end
		else if (wr_en)
		begin
			nxt_q.rd          = q_ff.mem[q_ff.ptr];
			nxt_q.mem[q_ff.ptr] = wr_data;
			nxt_q.ptr         = q_ff.ptr + tpc_pkg::PTR_ONE;
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			q_ff <= '0;
		else
			q_ff <= nxt_q;
	end

	assign rd_data = q_ff.rd;

endmodule

//--- logic/tpc_skid_buf.sv
// two-entry buffer with valid and ready on both sides, all outputs registered
`timescale 1ns/100ps
module tpc_skid_buf
(
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         reset,
	// filling side
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [tpc_pkg::DATA_W-1:0]   in_data,
	// draining side
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic      [tpc_pkg::DATA_W-1:0]   out_data
);

	// whole module state: head entry 0, tail entry 1
	typedef struct packed {
		logic                       v0;
		logic                       v1;
		logic [tpc_pkg::DATA_W-1:0] d0;
		logic [tpc_pkg::DATA_W-1:0] d1;
	} tpc_buf_t;

	tpc_buf_t q_ff;      // registered state
	tpc_buf_t nxt_q;     // next state

	// pop first, then push into the first free slot
	always_comb
	begin
		nxt_q = q_ff;
		if (q_ff.v0 && out_ready)
		begin
			nxt_q.v0 = q_ff.v1;
			nxt_q.d0 = q_ff.d1;
			nxt_q.v1 = 1'b0;
		end
		if (in_valid && !q_ff.v1)
		begin
			if (!nxt_q.v0)
			begin
				nxt_q.v0 = 1'b1;
				nxt_q.d0 = in_data;
			end
			else
			begin
				nxt_q.v1 = 1'b1;
				nxt_q.d1 = in_data;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			q_ff <= '0;
		else
			q_ff <= nxt_q;
	end

	// full only when the tail slot holds a word
	assign in_ready  = !q_ff.v1;
	assign out_valid = q_ff.v0;
	assign out_data  = q_ff.d0;

endmodule

//--- verif/tpc_capture_asserts.sv
// port-level checker for the tachometer capture block
`timescale 1ns/100ps
module tpc_capture_chk
(
	// clock and reset
	input wire logic                        core_clk,
	input wire logic                        reset,
	// sampler side
	input wire logic                        variant_16,
	input wire logic                        sample_req,
	input wire logic [tpc_pkg::CHAN_W-1:0]  sample_chan,
	input wire logic                        sample_ready,
	// stream side
	input wire logic                        out_valid,
	input wire logic                        out_ready,
	input wire logic [tpc_pkg::DATA_W-1:0]  out_data
);
	logic chan_hit; // request names the tachometer entry
	logic take;     // request accepted at this edge
	assign chan_hit = sample_chan == (variant_16 ? tpc_pkg::TACHO_CHAN_16 : tpc_pkg::TACHO_CHAN_8);
	assign take = sample_req && sample_ready && chan_hit;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// reset must not be masked here, it is the cause under test
	chk_reset_idle: assert property (disable iff (1'b0)
		reset |-> !out_valid && sample_ready && out_data == '0)
		else $error("reset state wrong");
	chk_ready_drop: assert property (take |=> !sample_ready)
		else $error("ready high after take");
	chk_ready_back: assert property (take && !out_valid |-> ##1 !sample_ready ##1 sample_ready)
		else $error("ready not back after one cycle");
	chk_valid_after: assert property (take && !out_valid |-> ##2 out_valid)
		else $error("word late");
	chk_valid_cause: assert property ($rose(out_valid) |-> $past(take, 2))
		else $error("word without take");
	chk_data_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("stalled word changed");
	chk_valid_drop: assert property ($fell(out_valid) |-> $past(out_ready))
		else $error("word dropped untaken");
	chk_chan_ignored: assert property (sample_req && sample_ready && !chan_hit && !out_valid |-> ##2 !out_valid)
		else $error("other channel taken");
	// main scenarios reached
	cov_take16: cover property (take && variant_16);
	cov_stall: cover property (out_valid && !out_ready ##1 out_valid && !out_ready);
	cov_full: cover property (!sample_ready [*4]);
endmodule

bind tpc_capture tpc_capture_chk tpc_capture_chk_inst
(
	.core_clk(core_clk),
	.reset(reset),
	.variant_16(variant_16),
	.sample_req(sample_req),
	.sample_chan(sample_chan),
	.sample_ready(sample_ready),
	.out_valid(out_valid),
	.out_ready(out_ready),
	.out_data(out_data)
);

//--- verif/tpc_tacho_src.sv
// tachometer pulse source: square wave of programmable half period
`timescale 1ns/100ps
module tpc_tacho_src
(
	// clock
	input  wire logic        core_clk,
	// control
	input  wire logic        run,
	input  wire logic [15:0] half,
	// pulse
	output logic             tacho
);
	logic [15:0] cnt_ff = 16'h0; // cycles spent in this half
	initial tacho = 1'b0;
	// toggle after half cycles; a stopped source stands still
	always @(posedge core_clk)
		if (run && cnt_ff + 16'h1 >= half)
		begin
			cnt_ff <= 16'h0;
			tacho <= ~tacho;
		end
		else if (run)
			cnt_ff <= cnt_ff + 16'h1;
endmodule

//--- verif/test_tacho_period_capture.sv
// self-checking bench of the tachometer capture block
`timescale 1ns/100ps
module test_tacho_period_capture;
	logic        core_clk = 1'b0;
	logic        reset;
	logic        tacho_in;
	logic        acq_start = 1'b0;
	logic        edge_rise_sel = 1'b1;
	logic        stale_en = 1'b1;
	logic        variant_16 = 1'b0;
	logic        sample_req = 1'b0;
	logic [4:0]  sample_chan = 5'h08;
	logic        sample_ready;
	logic        out_valid;
	logic        out_ready = 1'b1;
	logic [31:0] out_data;
	logic        tacho_run = 1'b0;
	logic [15:0] tacho_half = 16'h0032; // 100-cycle period gives 30 ticks
	int          fails = 0;
	int          checks_done = 0;
	logic [32:0] expq[$]; // {check, word} in stream order
	// 40 mhz clock
	always #12.5 core_clk = ~core_clk;
	tpc_capture tpc_capture_inst (.core_clk(core_clk), .reset(reset), .tacho_in(tacho_in),
		.acq_start(acq_start), .edge_rise_sel(edge_rise_sel), .stale_en(stale_en),
		.variant_16(variant_16), .sample_req(sample_req), .sample_chan(sample_chan),
		.sample_ready(sample_ready), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data));
	tpc_tacho_src tpc_tacho_src_inst (.core_clk(core_clk), .run(tacho_run), .half(tacho_half),
		.tacho(tacho_in));
	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		cmp_word(what, {31'h0, exp}, {31'h0, got});
	endtask
	// one take; its word leaves eight takes later, so expectations queue up
	task automatic samp(input logic [31:0] exp, input logic chk, input logic dopop);
		int n;
		@(posedge core_clk);
		sample_req <= 1'b1;
		sample_chan <= variant_16 ? tpc_pkg::TACHO_CHAN_16 : tpc_pkg::TACHO_CHAN_8;
		n = 0;
		do @(negedge core_clk); while (!sample_ready && ++n < 50);
		cmp_bit("sample_ready", 1'b1, sample_ready);
		@(posedge core_clk);
		sample_req <= 1'b0;
		expq.push_back({chk, exp});
		if (dopop)
			pop();
	endtask
	// collect one stream word and judge it against the queue head
	task automatic pop();
		int n;
		logic [32:0] e;
		n = 0;
		@(negedge core_clk);
		while (!out_valid && n++ < 50) @(negedge core_clk);
		cmp_bit("out_valid", 1'b1, out_valid);
		e = expq.pop_front();
		if (e[32])
			cmp_word("out_data", e[31:0], out_data);
		@(posedge core_clk);
	endtask
	task automatic start_acq();
		@(posedge core_clk);
		acq_start <= 1'b1;
		@(posedge core_clk);
		acq_start <= 1'b0;
		expq = {};
		repeat (8) expq.push_back({1'b1, 32'h0});
	endtask
	task automatic t_reset();
		cmp_bit("out_valid", 1'b0, out_valid);
		cmp_bit("sample_ready", 1'b1, sample_ready);
		cmp_word("out_data", 32'h0, out_data);
		$display("test reset done");
	endtask
	task automatic t_stale_on();
		start_acq();
		tacho_run <= 1'b1;
		samp(32'h80000000, 1'b1, 1'b1);
		samp(32'h80000000, 1'b1, 1'b1);
		repeat (250) @(posedge core_clk);
		samp(32'h0000001f, 1'b1, 1'b1);
		samp(32'h8000001f, 1'b1, 1'b1);
		tacho_half <= 16'h0064;
		repeat (700) @(posedge core_clk);
		samp(32'h0000003d, 1'b1, 1'b1);
		repeat (8) samp(32'h0, 1'b0, 1'b1);
		$display("test marker on done");
	endtask
	task automatic t_stale_off();
		stale_en <= 1'b0;
		edge_rise_sel <= 1'b0;
		variant_16 <= 1'b1;
		tacho_half <= 16'h0032;
		start_acq();
		// the old channel number no longer names the tachometer
		sample_chan <= tpc_pkg::TACHO_CHAN_8;
		sample_req <= 1'b1;
		repeat (4) @(negedge core_clk) cmp_bit("out_valid", 1'b0, out_valid);
		@(posedge core_clk);
		sample_req <= 1'b0;
		samp(32'h0, 1'b1, 1'b1);
		repeat (250) @(posedge core_clk);
		samp(32'h0000001f, 1'b1, 1'b1);
		samp(32'h0000001f, 1'b1, 1'b1);
		repeat (8) samp(32'h0000001f, 1'b1, 1'b1);
		$display("test marker off done");
	endtask
	task automatic t_stall();
		out_ready <= 1'b0;
		repeat (3) samp(32'h0000001f, 1'b1, 1'b0);
		@(posedge core_clk);
		sample_req <= 1'b1;
		repeat (10) @(negedge core_clk) cmp_bit("sample_ready", 1'b0, sample_ready);
		@(posedge core_clk);
		sample_req <= 1'b0;
		out_ready <= 1'b1;
		repeat (3) pop();
		$display("test stall done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial
	begin
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		t_reset();
		t_stale_on();
		t_stale_off();
		t_stall();
		tally_and_finish();
	end
	// watchdog, well beyond the under two thousand cycles the tests need
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		tally_and_finish();
	end
endmodule
